// file: pga_gain_channel.v
// one pga channel: staged gain, active gain, zero-cross deferral
// assumes update and zero-cross pulses on clk_in, sync done upstream
`timescale 1ns/10ps
`default_nettype none
`include "pga_gain_consts.vh"

module pga_gain_channel (
  input wire clk_in,
  input wire reset_in,
  input wire update_in,
  input wire zero_cross_en_in,
  input wire zero_cross_in,
  input wire timeout_in,
  input wire [`GAIN_WIDTH-1:0] staged_gain_in,
  output reg [`GAIN_WIDTH-1:0] active_gain_out,
  output reg pending_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // held code waiting for a crossing or timeout
  reg [`GAIN_WIDTH-1:0] held_reg;

  // apply now, or defer until crossing or timeout, first one wins
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      active_gain_out <= `GAIN_RESET;
      held_reg <= `GAIN_RESET;
      pending_out <= 1'b0;
    end else if (update_in) begin
      if (zero_cross_en_in) begin
        held_reg <= staged_gain_in;
        pending_out <= 1'b1;
      end else begin
        active_gain_out <= staged_gain_in;
        pending_out <= 1'b0;
      end
    end else if (pending_out && (zero_cross_in || timeout_in)) begin
      active_gain_out <= held_reg;
      pending_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: pga_gain_consts.vh
// register offsets, field positions, reset values and timing counts for the pga gain block
// assumes inclusion by bare name from the design files
`ifndef PGA_GAIN_CONSTS_VH
`define PGA_GAIN_CONSTS_VH

// register indices as printed; byte address is four times the index
`define IDX_LEFT_PAIR_A 8'h18
`define IDX_LEFT_PAIR_B 8'h19
`define IDX_RIGHT_PAIR_A 8'h1a
`define IDX_RIGHT_PAIR_B 8'h1b
`define IDX_TIMEOUT_CTRL 8'h1c
`define IDX_ZC_STATUS 8'h1d

// channel register fields
`define BIT_UPDATE 8
`define BIT_MUTE 7
`define BIT_ZC_EN 6
`define GAIN_MSB 4
`define GAIN_WIDTH 5

// reset values
`define GAIN_RESET 5'h0b
`define MUTE_RESET 1'b1
`define ZC_EN_RESET 1'b0

// timeout control register fields
`define BIT_TIMEOUT_EN 0
`define TIMEOUT_LIMIT_LSB 8
`define TIMEOUT_LIMIT_WIDTH 16
`define TIMEOUT_LIMIT_RESET 16'h0400

// ahb transfer type
`define HTRANS_NONSEQ 2'b10

`endif

// file: pga_gain_control.v
// ahb-lite register slave and control for four input pga gain channels
// assumes one ahb master, single word transfers; zero-cross inputs come from pins
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pga_gain_consts.vh"

module pga_gain_control (
  input wire clk_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire [3:0] zero_cross_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  output reg [`GAIN_WIDTH-1:0] left_a_inv_gain_out,
  output reg [`GAIN_WIDTH-1:0] left_a_noninv_gain_out,
  output reg [`GAIN_WIDTH-1:0] left_b_inv_gain_out,
  output reg [`GAIN_WIDTH-1:0] left_b_noninv_gain_out,
  output reg [`GAIN_WIDTH-1:0] right_a_inv_gain_out,
  output reg [`GAIN_WIDTH-1:0] right_a_noninv_gain_out,
  output reg [`GAIN_WIDTH-1:0] right_b_inv_gain_out,
  output reg [`GAIN_WIDTH-1:0] right_b_noninv_gain_out,
  output reg [3:0] mute_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // stored register fields, index 0..3 = left a, left b, right a, right b
  reg [`GAIN_WIDTH-1:0] gain_code_reg [0:3];
  reg [3:0] mute_reg;
  reg [3:0] zero_cross_en_reg;
  reg zero_cross_timeout_en_reg;
  reg [`TIMEOUT_LIMIT_WIDTH-1:0] zero_cross_timeout_rate_reg;
  reg gain_update_trigger_reg;
  wire [`GAIN_WIDTH-1:0] active_gain [0:3];
  wire [3:0] pending;

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for the zero-cross pins, then edge of level change
  reg [3:0] zc_meta_reg;
  reg [3:0] zc_sync_reg;
  reg [3:0] zc_last_reg;
  wire [3:0] zc_event;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      zc_meta_reg <= 4'h0;
      zc_sync_reg <= 4'h0;
      zc_last_reg <= 4'h0;
    end else begin
      zc_meta_reg <= zero_cross_in;
      zc_sync_reg <= zc_meta_reg;
      zc_last_reg <= zc_sync_reg;
    end
  end

  // a crossing is any change of the sign level
  assign zc_event = zc_sync_reg ^ zc_last_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // timeout counter, runs while any channel waits
  reg [`TIMEOUT_LIMIT_WIDTH-1:0] timeout_count_reg;
  reg timeout_pulse_reg;
  wire any_pending;

  assign any_pending = |pending;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      timeout_count_reg <= 16'h0000;
      timeout_pulse_reg <= 1'b0;
    end else if (!zero_cross_timeout_en_reg || !any_pending || gain_update_trigger_reg) begin
      timeout_count_reg <= 16'h0000;
      timeout_pulse_reg <= 1'b0;
    end else if (timeout_count_reg >= zero_cross_timeout_rate_reg) begin
      timeout_count_reg <= 16'h0000;
      timeout_pulse_reg <= 1'b1;
    end else begin
      timeout_count_reg <= timeout_count_reg + 16'h0001;
      timeout_pulse_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  reg wr_pend_reg;
  reg [7:0] wr_idx_reg;
  wire bus_take;
  wire [7:0] addr_idx;

  assign bus_take = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);
  assign addr_idx = haddr_in[9:2];

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take && hwrite_in;
      wr_idx_reg <= addr_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data phase write into the register fields
  wire wr_chan;
  wire [1:0] wr_chan_sel;

  assign wr_chan = wr_pend_reg && (wr_idx_reg >= `IDX_LEFT_PAIR_A) &&
                   (wr_idx_reg <= `IDX_RIGHT_PAIR_B);
  assign wr_chan_sel = wr_idx_reg[1:0];

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gain_code_reg[0] <= `GAIN_RESET;
      gain_code_reg[1] <= `GAIN_RESET;
      gain_code_reg[2] <= `GAIN_RESET;
      gain_code_reg[3] <= `GAIN_RESET;
      mute_reg <= {4{`MUTE_RESET}};
      zero_cross_en_reg <= {4{`ZC_EN_RESET}};
      zero_cross_timeout_en_reg <= 1'b0;
      zero_cross_timeout_rate_reg <= `TIMEOUT_LIMIT_RESET;
      gain_update_trigger_reg <= 1'b0;
    end else begin
      gain_update_trigger_reg <= 1'b0;
      if (wr_chan) begin
        // store only; active gain moves on the update pulse
        gain_code_reg[wr_chan_sel] <= hwdata_in[`GAIN_MSB:0];
        mute_reg[wr_chan_sel] <= hwdata_in[`BIT_MUTE];
        zero_cross_en_reg[wr_chan_sel] <= hwdata_in[`BIT_ZC_EN];
        gain_update_trigger_reg <= hwdata_in[`BIT_UPDATE];
      end
      if (wr_pend_reg && wr_idx_reg == `IDX_TIMEOUT_CTRL) begin
        zero_cross_timeout_en_reg <= hwdata_in[`BIT_TIMEOUT_EN];
        zero_cross_timeout_rate_reg <=
          hwdata_in[`TIMEOUT_LIMIT_LSB+`TIMEOUT_LIMIT_WIDTH-1:`TIMEOUT_LIMIT_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, registered in the cycle after the address phase
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    case (addr_idx)
      `IDX_LEFT_PAIR_A, `IDX_LEFT_PAIR_B, `IDX_RIGHT_PAIR_A, `IDX_RIGHT_PAIR_B: begin
        rd_next = {24'h0000_00, mute_reg[addr_idx[1:0]], zero_cross_en_reg[addr_idx[1:0]],
                   1'b0, gain_code_reg[addr_idx[1:0]]};
      end
      `IDX_TIMEOUT_CTRL: begin
        rd_next = {8'h00, zero_cross_timeout_rate_reg, 7'h00, zero_cross_timeout_en_reg};
      end
      `IDX_ZC_STATUS: begin
        rd_next = {28'h0000_000, pending};
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (bus_take && !hwrite_in) begin
        hrdata_out <= rd_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // four channels share one update pulse; those with zero-cross off change together
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : chan
      pga_gain_channel u_chan (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .update_in(gain_update_trigger_reg),
        .zero_cross_en_in(zero_cross_en_reg[ch]),
        .zero_cross_in(zc_event[ch]),
        .timeout_in(timeout_pulse_reg),
        .staged_gain_in(gain_code_reg[ch]),
        .active_gain_out(active_gain[ch]),
        .pending_out(pending[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // pga drive: same code on both inputs, code is linear 1.5dB steps
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      left_a_inv_gain_out <= `GAIN_RESET;
      left_a_noninv_gain_out <= `GAIN_RESET;
      left_b_inv_gain_out <= `GAIN_RESET;
      left_b_noninv_gain_out <= `GAIN_RESET;
      right_a_inv_gain_out <= `GAIN_RESET;
      right_a_noninv_gain_out <= `GAIN_RESET;
      right_b_inv_gain_out <= `GAIN_RESET;
      right_b_noninv_gain_out <= `GAIN_RESET;
      mute_out <= {4{`MUTE_RESET}};
    end else begin
      left_a_inv_gain_out <= active_gain[0];
      left_a_noninv_gain_out <= active_gain[0];
      left_b_inv_gain_out <= active_gain[1];
      left_b_noninv_gain_out <= active_gain[1];
      right_a_inv_gain_out <= active_gain[2];
      right_a_noninv_gain_out <= active_gain[2];
      right_b_inv_gain_out <= active_gain[3];
      right_b_noninv_gain_out <= active_gain[3];
      mute_out <= mute_reg;
    end
  end

endmodule
`default_nettype wire

// file: pga_gain_control_asserts.sv
// checker for the pga gain block, bound to its top module
// assumes single-word ahb transfers and the stated output latencies
`timescale 1ns/10ps
`default_nettype none
`include "pga_gain_consts.vh"
module pga_gain_control_asserts (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [4:0] left_a_inv_gain_out,
  input wire logic [4:0] left_a_noninv_gain_out,
  input wire logic [4:0] left_b_inv_gain_out,
  input wire logic [4:0] left_b_noninv_gain_out,
  input wire logic [4:0] right_a_inv_gain_out,
  input wire logic [4:0] right_a_noninv_gain_out,
  input wire logic [4:0] right_b_inv_gain_out,
  input wire logic [4:0] right_b_noninv_gain_out,
  input wire logic [3:0] mute_out
);
  logic wv_reg, rz_reg, uv_reg;
  logic [1:0] wch_reg, uch_reg;
  logic [4:0] ucode_reg;
  wire tk = hsel_in && hready_in && htrans_in == `HTRANS_NONSEQ;
  wire upd = wv_reg && hwdata_in[`BIT_UPDATE] && !hwdata_in[`BIT_ZC_EN];
  wire [19:0] inv = {right_b_inv_gain_out, right_a_inv_gain_out,
    left_b_inv_gain_out, left_a_inv_gain_out};
  wire [19:0] non = {right_b_noninv_gain_out, right_a_noninv_gain_out,
    left_b_noninv_gain_out, left_a_noninv_gain_out};
  ////////////////////////////////////////////////////////////////
  // data phase tracking and immediate update capture
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wv_reg <= 1'b0;
      rz_reg <= 1'b0;
      uv_reg <= 1'b0;
      wch_reg <= 2'b00;
      uch_reg <= 2'b00;
      ucode_reg <= 5'h00;
    end else begin
      wv_reg <= tk && hwrite_in && haddr_in[31:4] == 28'h000_0006;
      rz_reg <= tk && !hwrite_in && haddr_in[31:5] != 27'h000_0003;
      wch_reg <= haddr_in[3:2];
      uv_reg <= upd;
      if (upd) begin
        uch_reg <= wch_reg;
        ucode_reg <= hwdata_in[4:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_PAIR_EQUAL: assert property (inv == non)
    else $error("gain pair differs");
  AST_RESET_GAIN: assert property ($fell(reset_in) |-> inv == {4{`GAIN_RESET}})
    else $error("gain not at reset code");
  AST_RESET_MUTE: assert property ($fell(reset_in) |-> mute_out == 4'hf)
    else $error("mute not set after reset");
  AST_MUTE_FOLLOWS: assert property (wv_reg |-> ##2
    mute_out[$past(wch_reg, 2)] == $past(hwdata_in[`BIT_MUTE], 2)) else $error("mute mismatch");
  AST_IMMEDIATE: assert property (uv_reg |-> ##[2:3] inv[uch_reg*5 +: 5] == ucode_reg)
    else $error("immediate gain not applied");
  AST_READY: assert property (hreadyout_out == 1'b1)
    else $error("wait state seen");
  AST_OKAY: assert property (hresp_out == 1'b0)
    else $error("error response seen");
  AST_UNMAPPED_READ: assert property (rz_reg |-> hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind pga_gain_control pga_gain_control_asserts chk_i (.clk_in(clk_in), .reset_in(reset_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .mute_out(mute_out),
  .left_a_inv_gain_out(left_a_inv_gain_out), .left_a_noninv_gain_out(left_a_noninv_gain_out),
  .left_b_inv_gain_out(left_b_inv_gain_out), .left_b_noninv_gain_out(left_b_noninv_gain_out),
  .right_a_inv_gain_out(right_a_inv_gain_out), .right_a_noninv_gain_out(right_a_noninv_gain_out),
  .right_b_inv_gain_out(right_b_inv_gain_out), .right_b_noninv_gain_out(right_b_noninv_gain_out));
`default_nettype wire

// file: tb_input_pga_volume_control.sv
// self-checking bench for the pga gain block over ahb-lite
// assumes zero-wait slave; hready fed back from hreadyout
`timescale 1ns/10ps
`default_nettype none
`include "pga_gain_consts.vh"
module tb_input_pga_volume_control;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic [1:0] htrans_in = 2'b00;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic [3:0] zero_cross_in = 4'h0;
  logic [31:0] rd;
  logic [4:0] act [4];
  logic [4:0] stg [4];
  logic [3:0] mu;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int k;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out;
  wire [3:0] mute_out;
  wire [4:0] gi [4];
  wire [4:0] gn [4];
  pga_gain_control uut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .zero_cross_in(zero_cross_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .left_a_inv_gain_out(gi[0]), .left_a_noninv_gain_out(gn[0]),
    .left_b_inv_gain_out(gi[1]), .left_b_noninv_gain_out(gn[1]),
    .right_a_inv_gain_out(gi[2]), .right_a_noninv_gain_out(gn[2]),
    .right_b_inv_gain_out(gi[3]), .right_b_noninv_gain_out(gn[3]), .mute_out(mute_out));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] wrd(input logic u, m, z, input logic [4:0] g);
    return {23'h0, u, m, z, 1'b0, g};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= `HTRANS_NONSEQ;
    haddr_in <= a;
    hwrite_in <= wr;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic chk_all();
    for (int i = 0; i < 4; i++) begin
      chk("inv gain", {27'h0, act[i]}, {27'h0, gi[i]});
      chk("noninv gain", {27'h0, act[i]}, {27'h0, gn[i]});
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h55f924bc));
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      act[i] = `GAIN_RESET;
      ahb(1'b0, 32'h0000_0060 + 32'(4 * i), 32'h0000_0000);
      chk("chan reset", wrd(1'b0, 1'b1, 1'b0, `GAIN_RESET), rd);
    end
    chk_all();
    chk("mute reset", 32'h0000_000f, {28'h0, mute_out});
    ahb(1'b0, 32'h0000_0070, 32'h0000_0000);
    chk("timeout reset", 32'h0004_0000, rd);
    ahb(1'b0, 32'h0000_0080, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 4; i++) begin
        stg[i] = (n == 0) ? 5'h00 : (n == 1) ? 5'h1f : 5'($urandom);
        mu[i] = 1'($urandom);
        ahb(1'b1, 32'h0000_0060 + 32'(4 * i), wrd(1'b0, mu[i], 1'b0, stg[i]));
      end
      repeat (4) @(posedge clk_in);
      chk_all();
      chk("mute", {28'h0, mu}, {28'h0, mute_out});
      k = $urandom_range(3);
      ahb(1'b1, 32'h0000_0060 + 32'(4 * k), wrd(1'b1, mu[k], 1'b0, stg[k]));
      ahb(1'b0, 32'h0000_0060 + 32'(4 * k), 32'h0000_0000);
      chk("readback", wrd(1'b0, mu[k], 1'b0, stg[k]), rd);
      repeat (3) @(posedge clk_in);
      act = stg;
      chk_all();
    end
    $display("test update done");
    for (int t = 0; t < 2; t++) begin
      k = $urandom_range(3);
      stg[k] = ~act[k];
      if (t == 1) ahb(1'b1, 32'h0000_0070, 32'h0000_0401);
      ahb(1'b1, 32'h0000_0060 + 32'(4 * k), wrd(1'b1, mu[k], 1'b1, stg[k]));
      if (t == 0) begin
        repeat (20) @(posedge clk_in);
        chk_all();
        ahb(1'b0, 32'h0000_0074, 32'h0000_0000);
        chk("pending", 32'h1 << k, rd);
        zero_cross_in[k] <= ~zero_cross_in[k];
      end
      repeat (20) @(posedge clk_in);
      act[k] = stg[k];
      chk_all();
      ahb(1'b0, 32'h0000_0074, 32'h0000_0000);
      chk("pending clear", 32'h0000_0000, rd);
    end
    $display("test zero cross done");
    complete_run();
  end
endmodule
`default_nettype wire
